// *** logic/pslt_transmitter.sv ***
// parallel-to-serial link transmitter: wishbone registers on the reference
// clock, serializer and frame clock on the fast bit clock
// assumes the fast clock is ratio times the reference clock
`timescale 1ns/10ps
`default_nettype none
// Function
// - capture word on first fast edge after frame
// - shift one bit per fast clock edge
// - bit zero out on third fast edge
// - remaining bits follow in ascending order
// - frame clock rises on first fast edge
// - enable low tristates data and frame clock
// - enable high drives data, and frame clock when its enable is high
// - frame clock enable gates frame clock driver
// - chain enable low blocks chain input
// - ratio up to ten ignores chain input
// - ratio above ten appends chain bits
// - positions past ratio carry invalid data
// - ten-bit parallel-in serial-out shift register
// - lock low resets and forces outputs low
// - enable low resets, outputs start low
module pslt_transmitter (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_reset,
	input  wire logic                        i_fast_bit_clk,
	input  wire logic [pslt_pkg::DATA_W-1:0] i_parallel_in,
	input  wire logic                        i_pll_locked_in,
	input  wire logic                        i_chain_serial_in,
	input  wire logic                        i_wb_cyc,
	input  wire logic                        i_wb_stb,
	input  wire logic                        i_wb_we,
	input  wire logic [pslt_pkg::ADR_W-1:0]  i_wb_adr,
	input  wire logic [3:0]                  i_wb_sel,
	input  wire logic [pslt_pkg::WB_W-1:0]   i_wb_dat,
	output logic [pslt_pkg::WB_W-1:0]        o_wb_dat,
	output logic                             o_wb_ack,
	output logic                             o_serial_data,
	output logic                             o_serial_data_oe,
	output logic                             o_frame_clock_out,
	output logic                             o_frame_clock_out_oe
);
	localparam int unsigned SYNC_W = pslt_pkg::RATIO_W + 6;

	// ---------------- reference clock domain ----------------
	logic                        en_reg;
	logic                        fco_en_reg;
	logic                        chain_en_reg;
	logic [pslt_pkg::RATIO_W-1:0] ratio_reg;
	logic                        ack_reg;
	logic [pslt_pkg::WB_W-1:0]   rdat_reg;
	logic [pslt_pkg::DATA_W-1:0] pin_s1_reg;
	logic [pslt_pkg::DATA_W-1:0] pin_s2_reg;
	logic [pslt_pkg::DATA_W-1:0] word_reg;
	logic                        frame_tog_reg;
	logic                        lock_s1_reg;
	logic                        lock_s2_reg;
	logic                        run_s1_reg;
	logic                        run_s2_reg;
	logic                        bus_req;
	logic                        run_flag;

	assign bus_req = i_wb_cyc & i_wb_stb;

	// wishbone slave: ack one cycle after the request, dropped the next cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
		end
	end

	// writes land on the edge where the master samples ack
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			en_reg       <= pslt_pkg::CTRL_EN_RST;
			fco_en_reg   <= pslt_pkg::CTRL_FCO_RST;
			chain_en_reg <= pslt_pkg::CTRL_CHAIN_RST;
			ratio_reg    <= pslt_pkg::RATIO_RST;
		end else if (bus_req & i_wb_we & ack_reg & (i_wb_adr == pslt_pkg::CTRL_ADDR)) begin
			if (i_wb_sel[0]) begin
				en_reg       <= i_wb_dat[pslt_pkg::CTRL_EN_BIT];
				fco_en_reg   <= i_wb_dat[pslt_pkg::CTRL_FCO_BIT];
				chain_en_reg <= i_wb_dat[pslt_pkg::CTRL_CHAIN_BIT];
			end
			if (i_wb_sel[1]) begin
				ratio_reg <= i_wb_dat[pslt_pkg::CTRL_RATIO_MSB:pslt_pkg::CTRL_RATIO_LSB];
			end
		end
	end

	// read data is prepared on the edge that raises ack; unmapped reads give zero
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rdat_reg <= '0;
		end else if (bus_req & ~ack_reg & ~i_wb_we) begin
			rdat_reg <= '0;
			if (i_wb_adr == pslt_pkg::CTRL_ADDR) begin
				rdat_reg[pslt_pkg::CTRL_EN_BIT]    <= en_reg;
				rdat_reg[pslt_pkg::CTRL_FCO_BIT]   <= fco_en_reg;
				rdat_reg[pslt_pkg::CTRL_CHAIN_BIT] <= chain_en_reg;
				rdat_reg[pslt_pkg::CTRL_RATIO_MSB:pslt_pkg::CTRL_RATIO_LSB] <= ratio_reg;
			end else if (i_wb_adr == pslt_pkg::STATUS_ADDR) begin
				rdat_reg[pslt_pkg::STAT_LOCK_BIT] <= lock_s2_reg;
				rdat_reg[pslt_pkg::STAT_RUN_BIT]  <= run_s2_reg;
			end else if (i_wb_adr == pslt_pkg::WORD_ADDR) begin
				rdat_reg[pslt_pkg::DATA_W-1:0] <= word_reg;
			end
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;

	// parallel pins pass two flops, then the frame word holds for one reference period
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			pin_s1_reg    <= '0;
			pin_s2_reg    <= '0;
			word_reg      <= '0;
			frame_tog_reg <= 1'b0;
		end else begin
			pin_s1_reg    <= i_parallel_in;
			pin_s2_reg    <= pin_s1_reg;
			word_reg      <= pin_s2_reg;
			frame_tog_reg <= ~frame_tog_reg;
		end
	end

	// status levels from the pin and from the fast domain
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			lock_s1_reg <= 1'b0;
			lock_s2_reg <= 1'b0;
			run_s1_reg  <= 1'b0;
			run_s2_reg  <= 1'b0;
		end else begin
			lock_s1_reg <= i_pll_locked_in;
			lock_s2_reg <= lock_s1_reg;
			run_s1_reg  <= run_flag;
			run_s2_reg  <= run_s1_reg;
		end
	end

	// ---------------- fast bit clock domain ----------------
	// config is quasi-static: software must change ratio only while disabled
	logic [SYNC_W-1:0]           f_s1_reg;
	logic [SYNC_W-1:0]           f_s2_reg;
	logic                        f_tog_d_reg;
	logic                        f_lock_s1_reg;
	logic                        f_lock_s2_reg;
	logic                        f_rst;
	logic                        f_en;
	logic                        f_fco_en;
	logic                        f_chain_en;
	logic [pslt_pkg::RATIO_W-1:0] f_ratio;
	logic                        f_run;
	logic                        f_load;
	logic [pslt_pkg::DATA_W-1:0] f_shreg;
	logic [pslt_pkg::PHASE_W-1:0] f_phase;
	logic                        f_chain_reg;
	logic                        sd_reg;
	logic                        sd_oe_reg;
	logic                        fc_reg;
	logic                        fc_oe_reg;
	logic [pslt_pkg::PHASE_W-1:0] f_phase_next;

	always_ff @(posedge i_fast_bit_clk) begin
		f_s1_reg      <= {i_reset, frame_tog_reg, en_reg, fco_en_reg, chain_en_reg,
			1'b0, ratio_reg};
		f_s2_reg      <= f_s1_reg;
		f_lock_s1_reg <= i_pll_locked_in;
		f_lock_s2_reg <= f_lock_s1_reg;
	end

	assign f_rst      = f_s2_reg[SYNC_W-1];
	assign f_en       = f_s2_reg[SYNC_W-3];
	assign f_fco_en   = f_s2_reg[SYNC_W-4];
	assign f_chain_en = f_s2_reg[SYNC_W-5];
	assign f_ratio    = f_s2_reg[pslt_pkg::RATIO_W-1:0];
	// enable low and lock low both hold the serializer in reset
	assign f_run      = ~f_rst & f_en & f_lock_s2_reg;
	assign run_flag   = f_run;

	always_ff @(posedge i_fast_bit_clk) begin
		f_tog_d_reg <= f_s2_reg[SYNC_W-2];
	end

	// a toggle edge, two flops late, marks the third fast edge after a reference edge
	assign f_load = f_run & (f_tog_d_reg ^ f_s2_reg[SYNC_W-2]);

	assign f_phase_next = (f_phase == pslt_pkg::PHASE_IDLE) ? f_phase :
		f_phase + pslt_pkg::PHASE_FIRST;

	// ten-bit shift register, loaded whole then shifted low bit first
	always_ff @(posedge i_fast_bit_clk) begin
		if (~f_run) begin
			f_shreg <= '0;
			f_phase <= pslt_pkg::PHASE_IDLE;
		end else if (f_load) begin
			f_shreg <= word_reg;
			f_phase <= '0;
		end else begin
			if (f_phase != '0 && f_phase != pslt_pkg::PHASE_IDLE) begin
				f_shreg <= {1'b0, f_shreg[pslt_pkg::DATA_W-1:1]};
			end
			f_phase <= f_phase_next;
		end
	end

	// chain input shares the fast clock with the unit before it, so one flop
	always_ff @(posedge i_fast_bit_clk) begin
		if (~f_run | ~f_chain_en) begin
			f_chain_reg <= 1'b0;
		end else begin
			f_chain_reg <= i_chain_serial_in;
		end
	end

	// output bit index is phase minus one, so bit zero leaves two edges after the load
	always_ff @(posedge i_fast_bit_clk) begin
		if (~f_run) begin
			sd_reg <= 1'b0;
		end else if (f_phase == '0 || f_phase > f_ratio) begin
			sd_reg <= 1'b0;
		end else if (f_phase > pslt_pkg::PARALLEL_BITS) begin
			sd_reg <= f_chain_reg;
		end else begin
			sd_reg <= f_shreg[0];
		end
	end

	// frame clock high for the first half of the frame
	always_ff @(posedge i_fast_bit_clk) begin
		if (~f_run) begin
			fc_reg <= 1'b0;
		end else if (f_load) begin
			fc_reg <= 1'b1;
		end else begin
			fc_reg <= (f_phase_next < (f_ratio >> 1));
		end
	end

	always_ff @(posedge i_fast_bit_clk) begin
		if (f_rst) begin
			sd_oe_reg <= 1'b0;
			fc_oe_reg <= 1'b0;
		end else begin
			sd_oe_reg <= f_en;
			fc_oe_reg <= f_en & f_fco_en;
		end
	end

	assign o_serial_data        = sd_reg;
	assign o_serial_data_oe     = sd_oe_reg;
	assign o_frame_clock_out    = fc_reg;
	assign o_frame_clock_out_oe = fc_oe_reg;

	// ---------------- checks ----------------
	// the second edge after a load may already reload; bit zero still leaves on it
	sequence load_then_hold;
		(f_load) ##1 (f_run && !f_load) ##1 f_run;
	endsequence

	word_capture_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		f_load |=> (f_shreg == $past(word_reg)))
		else $error("frame word not captured on load");

	first_bit_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		load_then_hold |=> (o_serial_data == $past(word_reg[0], 3)))
		else $error("bit zero not on third fast edge");

	bit_order_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		(f_run && !f_load && f_phase >= 6'h02 && f_phase <= f_ratio
			&& f_phase <= pslt_pkg::PARALLEL_BITS)
		|=> (o_serial_data == $past(f_shreg[0])) && (f_shreg == ($past(f_shreg) >> 1)))
		else $error("parallel bits not shifted in order");

	chain_bits_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		(f_run && f_phase > pslt_pkg::PARALLEL_BITS && f_phase <= f_ratio
			&& f_phase != pslt_pkg::PHASE_IDLE)
		|=> (o_serial_data == $past(f_chain_reg)))
		else $error("chain bit not forwarded");

	invalid_pos_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		(f_phase > f_ratio) |=> !o_serial_data)
		else $error("position past ratio not zero");

	frame_rise_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		f_load |=> o_frame_clock_out)
		else $error("frame clock not high after load");

	disable_oe_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		!f_en |=> !o_serial_data_oe && !o_frame_clock_out_oe)
		else $error("outputs driven while disabled");

	enable_oe_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		f_en |=> o_serial_data_oe && (o_frame_clock_out_oe == $past(f_fco_en)))
		else $error("outputs not driven while enabled");

	fco_gate_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		!f_fco_en |=> !o_frame_clock_out_oe)
		else $error("frame clock driven while its enable is low");

	chain_block_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		!f_chain_en |=> !f_chain_reg)
		else $error("chain input passed while disabled");

	lock_low_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		!f_lock_s2_reg |=> !o_serial_data && !o_frame_clock_out
			&& f_phase == pslt_pkg::PHASE_IDLE)
		else $error("outputs not low while unlocked");

	enable_reset_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		$rose(f_en) |-> !o_serial_data && !o_frame_clock_out)
		else $error("outputs not low at enable");

	wb_ack_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(bus_req && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
		else $error("wishbone ack not single cycle");

	load_phase_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		f_load |=> (f_phase == '0))
		else $error("frame not restarted on load");

	empty_slot_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		(f_run && f_phase == '0) |=> !o_serial_data)
		else $error("slot before bit zero not low");

	idle_clear_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		!f_en |=> (f_shreg == '0) && (f_phase == pslt_pkg::PHASE_IDLE))
		else $error("serializer not cleared while disabled");

	chain_pass_a: assert property (@(posedge i_fast_bit_clk) disable iff (f_rst)
		(f_run && f_chain_en) |=> (f_chain_reg == $past(i_chain_serial_in)))
		else $error("chain input not taken while enabled");

	// software sees the same word that the serializer is fed
	sequence word_read_req;
		bus_req && !o_wb_ack && !i_wb_we && (i_wb_adr == pslt_pkg::WORD_ADDR);
	endsequence

	read_word_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		word_read_req |=> (o_wb_dat[pslt_pkg::DATA_W-1:0] == $past(word_reg)))
		else $error("frame word readback wrong");
endmodule : pslt_transmitter
`default_nettype wire

// *** logic/pslt_pkg.sv ***
// constants shared by the serializer-transmitter block
// assumes a 32-bit classic wishbone master and a fast bit clock from a multiplier
`default_nettype none
package pslt_pkg;
	localparam int unsigned DATA_W      = 10;
	localparam int unsigned RATIO_W     = 6;
	localparam int unsigned PHASE_W     = 6;
	localparam int unsigned ADR_W       = 8;
	localparam int unsigned WB_W        = 32;

	// register byte addresses
	localparam logic [7:0] CTRL_ADDR    = 8'h00;
	localparam logic [7:0] STATUS_ADDR  = 8'h04;
	localparam logic [7:0] WORD_ADDR    = 8'h08;

	// control fields
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_FCO_BIT   = 1;
	localparam int unsigned CTRL_CHAIN_BIT = 2;
	localparam int unsigned CTRL_RATIO_LSB = 8;
	localparam int unsigned CTRL_RATIO_MSB = 13;

	// status fields
	localparam int unsigned STAT_LOCK_BIT  = 0;
	localparam int unsigned STAT_RUN_BIT   = 1;

	// reset values
	localparam logic       CTRL_EN_RST    = 1'b0;
	localparam logic       CTRL_FCO_RST   = 1'b1;
	localparam logic       CTRL_CHAIN_RST = 1'b0;
	localparam logic [5:0] RATIO_RST      = 6'h0a;

	// frame layout
	localparam logic [5:0] PARALLEL_BITS  = 6'h0a;
	localparam logic [5:0] PHASE_IDLE     = 6'h3f;
	localparam logic [5:0] PHASE_FIRST    = 6'h01;
endpackage : pslt_pkg
`default_nettype wire

// *** tb/pslt_far_side.sv ***
// far side: clock multiplier and receiver watching the link pins
// assumes the bench asks for lock through i_lock_req
`timescale 1ns/10ps
`default_nettype none
module pslt_far_side (
	input  wire logic  i_lock_req,
	input  wire logic  i_serial_data,
	input  wire logic  i_serial_data_oe,
	input  wire logic  i_frame_clock_out,
	input  wire logic  i_frame_clock_out_oe,
	output logic       o_fast_bit_clk,
	output logic       o_pll_locked_in,
	output logic       o_chain_serial_in,
	output logic [15:0] o_fc_rises
);
	logic sd_lvl;
	logic fc_lvl;
	logic fc_prev;
	// free-running multiplied clock, phase offset on purpose
	initial begin
		o_fast_bit_clk = 1'b0;
		#7;
		forever #32 o_fast_bit_clk = ~o_fast_bit_clk;
	end
	assign o_pll_locked_in = i_lock_req;
	// undriven pins show the inverse of their last level, not a stale copy
	always @(posedge o_fast_bit_clk) begin
		sd_lvl <= i_serial_data_oe ? i_serial_data : ~sd_lvl;
		fc_lvl <= i_frame_clock_out_oe ? i_frame_clock_out : ~fc_lvl;
		fc_prev <= fc_lvl;
		o_chain_serial_in <= sd_lvl;
		if (i_frame_clock_out_oe && fc_lvl && !fc_prev) begin
			o_fc_rises <= o_fc_rises + 16'h0001;
		end
	end
	initial begin
		sd_lvl = 1'b0;
		fc_lvl = 1'b0;
		fc_prev = 1'b0;
		o_chain_serial_in = 1'b0;
		o_fc_rises = 16'h0000;
	end
endmodule : pslt_far_side
`default_nettype wire

// *** tb/pslt_transmitter_bench.sv ***
// bench for the serializer: wishbone master, word driver, pin checks
// assumes far-side model makes the fast clock and lock
`timescale 1ns/10ps
`default_nettype none
module pslt_transmitter_bench;
	logic        i_ref_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic [9:0]  i_parallel_in = 10'h000;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic        lock_req = 1'b1;
	wire         fclk, lock, chain, sd, sd_oe, fc, fc_oe, ack;
	wire  [31:0] rdat;
	wire  [15:0] rises;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] rnd = 32'd75;
	int          err_total = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          sd_highs = 0;
	int          hi_snap = 0;
	always #50 i_ref_clk = ~i_ref_clk;
	pslt_transmitter u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_fast_bit_clk(fclk),
		.i_parallel_in(i_parallel_in), .i_pll_locked_in(lock), .i_chain_serial_in(chain),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_serial_data(sd),
		.o_serial_data_oe(sd_oe), .o_frame_clock_out(fc), .o_frame_clock_out_oe(fc_oe));
	pslt_far_side u_far (.i_lock_req(lock_req), .i_serial_data(sd), .i_serial_data_oe(sd_oe),
		.i_frame_clock_out(fc), .i_frame_clock_out_oe(fc_oe), .o_fast_bit_clk(fclk),
		.o_pll_locked_in(lock), .o_chain_serial_in(chain), .o_fc_rises(rises));
	task automatic complete_run();
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xorshift
	// one classic cycle; reads leave their expectation for the monitor
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		if (!w) begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		@(posedge i_ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= w ? d : 32'h0;
		// ack is looked at on rising edges only; release follows the edge that saw it
		@(posedge i_ref_clk);
		while (ack !== 1'b1) @(posedge i_ref_clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic idle(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : idle
	always @(posedge i_ref_clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			check(rdat & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	// driven serial highs; frames are cut short by the bench clocks, so only bit zero shows
	always @(posedge fclk) begin
		if (sd === 1'b1 && sd_oe === 1'b1) begin
			sd_highs++;
		end
	end
	// whole run needs about 140 reference cycles
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			$display("Error at %0t: timeout", $time);
			complete_run();
		end
	end
	initial begin
		idle(12);
		i_reset <= 1'b0;
		wb(1'b0, 8'h00, 32'h0000_0a02, 32'h0000_3f07);
		idle(4);
		check({30'h0, sd_oe, fc_oe}, 32'h0);
		wb(1'b1, 8'h20, 32'hffff_ffff, 32'h0);
		wb(1'b0, 8'h20, 32'h0, 32'hffff_ffff);
		wb(1'b1, 8'h00, 32'h0000_0407, 32'h0);
		wb(1'b0, 8'h00, 32'h0000_0407, 32'h0000_3f07);
		idle(10);
		check({30'h0, sd_oe, fc_oe}, 32'h3);
		check({31'h0, rises != 16'h0}, 32'h1);
		wb(1'b0, 8'h04, 32'h0000_0003, 32'h0000_0003);
		for (int k = 0; k < 4; k++) begin
			rnd = xorshift(rnd);
			i_parallel_in <= rnd[9:0];
			idle(5);
			hi_snap = sd_highs;
			idle(6);
			check({31'h0, sd_highs != hi_snap}, {31'h0, rnd[0]});
			wb(1'b0, 8'h08, {22'h0, rnd[9:0]}, 32'h0000_03ff);
		end
		wb(1'b1, 8'h00, 32'h0000_0405, 32'h0);
		idle(6);
		check({30'h0, sd_oe, fc_oe}, 32'h2);
		lock_req <= 1'b0;
		idle(10);
		check({30'h0, sd, fc}, 32'h0);
		wb(1'b0, 8'h04, 32'h0, 32'h1);
		lock_req <= 1'b1;
		wb(1'b1, 8'h00, 32'h0000_1402, 32'h0);
		wb(1'b0, 8'h00, 32'h0000_1402, 32'h0000_3f07);
		idle(10);
		check({30'h0, sd_oe, fc_oe}, 32'h0);
		idle(2);
		complete_run();
	end
endmodule : pslt_transmitter_bench
`default_nettype wire
